// ---- verif/cmc_bus_model.sv ----
/*
 * far-side model: can bus activity and pending transmit buffers.
 * assumes the bench commands busy frames and loads pending buffers.
 */
`timescale 1ns/10ps
module cmc_bus_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic busy_i,
	input wire logic [2:0] load_i,
	input wire logic abort_i,
	output logic bus_idle_o,
	output logic [2:0] tx_pending_o
);
	// ************************************************
	// bus activity and transmit buffers
	// ************************************************
	logic [3:0] dly_r; // slow abort, so software sees the bit set
	// bus idle only outside a frame
	assign bus_idle_o = !busy_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dly_r <= 4'h0;
			tx_pending_o <= 3'h0;
		end else if (abort_i && dly_r == 4'hf) begin // all aborted at once
			dly_r <= 4'h0;
			tx_pending_o <= 3'h0;
		end else begin
			dly_r <= abort_i ? dly_r + 4'h1 : 4'h0;
			tx_pending_o <= tx_pending_o | load_i;
		end
	end
endmodule : cmc_bus_model

// ---- verif/test_can_mode_ctrl_int_code.sv ----
/*
 * self-checking bench for cmc_mode_ctrl over classic wishbone.
 * assumes cmc_bus_model on the engine side; seed fixed.
 */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; \
	$display("Error %s exp %h got %h", nm, ex, got); end end
module test_can_mode_ctrl_int_code;
	import cmc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, busy = 1'b0, ack, abrt, idle;
	logic [3:0] adr = 4'h0, fptr = 4'h0, sel = 4'hf;
	logic [2:0] load = 3'h0, pend;
	logic [31:0] wdat = 32'h0, rdat;
	logic [7:0] q;
	logic [4:0] e; // expected source code
	logic [2:0] wsel = 3'h7; // window left by the window sweep
	cmc_irq_s irq = '0;
	cmc_op_e mode;
	cmc_winbuf_e buffer_window_select;
	logic [4:0] code;
	int error_cnt = 0;
	int n_compared = 0;
	// ************************************************
	// clock, design and far side
	// ************************************************
	always #4 clk_i = ~clk_i;
	cmc_mode_ctrl cmc_mode_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .bus_idle_i(idle), .tx_pending_i(pend),
		.fifo_read_pointer_i(fptr), .irq_i(irq), .mode_in_effect_o(mode),
		.abort_all_tx_o(abrt), .buffer_window_o(buffer_window_select), .irq_source_code_o(code));
	cmc_bus_model cmc_bus_model_i (.clk_i(clk_i), .rst_i(rst_i), .busy_i(busy),
		.load_i(load), .abort_i(abrt), .bus_idle_o(idle), .tx_pending_o(pend));
	// ************************************************
	// tasks and expectations
	// ************************************************
	task automatic close_out;
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out
	// one classic cycle; hang counts as a mismatch
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			error_cnt++;
			close_out();
		end
	endtask : wb
	function automatic cmc_winbuf_e exp_win(input logic [2:0] w);
		case (w)
			3'h5: return WB_RX1;
			3'h4: return WB_TX0;
			3'h3: return WB_TX1;
			3'h2: return WB_TX2;
			default: return WB_RX0;
		endcase
	endfunction : exp_win
	// priority err, tx2, tx1, tx0, rx1, rx0, prog, wake
	function automatic logic [4:0] exp_code(input cmc_irq_s s, input int lay);
		if (s.bus_err) return 5'h02;
		if (s.tx[2]) return 5'h04;
		if (s.tx[1]) return 5'h06;
		if (s.tx[0]) return 5'h08;
		if (s.rx[1]) return lay == 0 ? 5'h0a : (lay == 2 ? 5'h10 : 5'h11);
		if (s.rx[0]) return lay == 0 ? 5'h0c : 5'h10;
		for (int n = 0; n < 6; n++)
			if (lay != 0 && s.prog[n]) return (lay == 2 && s.prog_rx[n]) ? 5'h10 : 5'(18 + n);
		return s.wake ? 5'h0e : 5'h00;
	endfunction : exp_code
	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		void'($urandom(32'h858a));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, 4'h0, 0);
		`CHK("ctrl rst", 8'h80, q)
		wb(0, 4'h4, 0);
		`CHK("stat rst", 8'h80, q)
		busy <= 1'b1;
		// m == 1 parks the controller asleep
		for (int m = 0; m < 4; m++) begin
			wb(1, 4'h0, 8'(m << 5));
			wb(0, 4'h4, 0);
			`CHK("mode", 8'(m << 5), q)
			`CHK("mode pin", 3'(m), mode)
		end
		wb(1, 4'h0, 8'he0);
		wb(0, 4'h4, 0);
		`CHK("cfg wait", 8'h60, q)
		busy <= 1'b0;
		wb(0, 4'h4, 0);
		`CHK("cfg idle", 8'h80, q)
		load <= 3'h7;
		wb(1, 4'h0, 8'h90);
		load <= 3'h0;
		wb(1, 4'h0, 8'h80);
		wb(0, 4'h0, 0);
		`CHK("abort held", 8'h90, q)
		wb(0, 4'hc, 0);
		`CHK("pend view", 8'h07, q)
		repeat (30) @(posedge clk_i);
		`CHK("abort done", 1'b0, abrt)
		wb(0, 4'hc, 0);
		`CHK("pend clr", 8'h00, q)
		for (int w = 0; w < 8; w++) begin
			wb(1, 4'h0, 8'(8'h81 | (w << 1)));
			wb(0, 4'h0, 0);
			`CHK("win rd", 8'(8'h80 | (w << 1)), q)
			`CHK("win map", exp_win(3'(w)), buffer_window_select)
		end
		wb(0, 4'h2, 0);
		`CHK("unmapped", 8'h00, q)
		for (int lay = 0; lay < 3; lay++) begin
			wb(1, 4'h8, 8'(lay));
			wb(0, 4'h8, 0);
			`CHK("layout", 8'(lay), q)
			for (int i = 0; i < 40; i++) begin
				// corner: every programmable buffer raised as a receiver
				irq <= i == 0 ? '0 : (i == 1 ? cmc_irq_s'(19'h00fff) :
					cmc_irq_s'(19'($urandom & $urandom & $urandom & $urandom)));
				fptr <= 4'($urandom & 7);
				wb(0, 4'h4, 0);
				e = exp_code(irq, lay);
				`CHK("code", e, code)
				`CHK("stat code", lay == 0 ? e & 5'h0e : e, q[4:0])
				if (lay == 0) wsel = e[3:1];
				// one status snapshot feeds the window copy
				wb(1, 4'h0, {3'h4, 1'b0, q[3:1], 1'b0});
				wb(0, 4'h0, 0);
				`CHK("ctrl low", lay == 2 ? fptr : (lay == 0 ? {wsel, 1'b0} : 4'h0), q[3:0])
				`CHK("win copy", exp_win(wsel), buffer_window_select)
			end
		end
		wb(1, 4'h8, 8'h03);
		wb(0, 4'h8, 0);
		`CHK("lay rsvd", 8'h02, q)
		sel <= 4'he;
		wb(1, 4'h0, 8'h00);
		sel <= 4'hf;
		wb(0, 4'h4, 0);
		`CHK("sel0 ign", 3'h4, q[7:5])
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, 4'h8, 0);
		`CHK("lay rst", 8'h00, q)
		`CHK("win rst", WB_RX0, buffer_window_select)
		close_out();
	end
endmodule : test_can_mode_ctrl_int_code

// ---- verilog/cmc_mode_ctrl.sv ----
/*
 * mode request/status, abort, window select and source code logic.
 * assumes a classic wishbone master and same-clock engine inputs.
 */
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module cmc_mode_ctrl #(
	parameter int N_PROG = 6
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic bus_idle_i,
	input wire logic [2:0] tx_pending_i,
	input wire logic [3:0] fifo_read_pointer_i,
	input wire cmc_pkg::cmc_irq_s irq_i,
	output cmc_pkg::cmc_op_e mode_in_effect_o,
	output logic abort_all_tx_o,
	output cmc_pkg::cmc_winbuf_e buffer_window_o,
	output logic [4:0] irq_source_code_o
);
	import cmc_pkg::*;

	// ************************************************
	// elaboration check
	// ************************************************
	// code space holds exactly six programmable buffers
	if (N_PROG != 6) begin : g_bad_prog
		$error("cmc_mode_ctrl: N_PROG must be 6");
	end

	// ************************************************
	// functions
	// ************************************************
	// legacy window field to buffer
	function automatic cmc_winbuf_e win_decode(input logic [2:0] w);
		cmc_winbuf_e b;
		b = WB_RX0;
		case (w)
			3'h5: b = WB_RX1;
			3'h4: b = WB_TX0;
			3'h3: b = WB_TX1;
			3'h2: b = WB_TX2;
			default: b = WB_RX0;
		endcase
		return b;
	endfunction : win_decode

	// highest priority source, lowest priority first
	function automatic logic [4:0] irq_code(input cmc_irq_s s, input cmc_layout_e l);
		logic [4:0] c;
		c = CMC_IC_NONE;
		if (s.wake) begin
			c = CMC_IC_WAKE;
		end
		if (l != LAY_LEGACY) begin
			for (int i = N_PROG - 1; i >= 0; i--) begin
				if (s.prog[i]) begin
					c = (l == LAY_FIFO && s.prog_rx[i]) ? CMC_IC_E_RX0 :
						5'(CMC_IC_PROG0 + 5'(i));
				end
			end
		end
		if (s.rx[0]) begin
			c = (l == LAY_LEGACY) ? CMC_IC_L_RX0 : CMC_IC_E_RX0;
		end
		if (s.rx[1]) begin
			c = (l == LAY_LEGACY) ? CMC_IC_L_RX1 :
				((l == LAY_FIFO) ? CMC_IC_E_RX0 : CMC_IC_E_RX1);
		end
		if (s.tx[0]) begin
			c = CMC_IC_TX0;
		end
		if (s.tx[1]) begin
			c = CMC_IC_TX1;
		end
		if (s.tx[2]) begin
			c = CMC_IC_TX2;
		end
		if (s.bus_err) begin
			c = CMC_IC_ERR;
		end
		return c;
	endfunction : irq_code

	// ************************************************
	// state
	// ************************************************
	logic [2:0] req_r; // requested mode
	cmc_op_e mode_r; // mode in effect
	logic abort_r; // abort in progress
	logic [2:0] win_r; // legacy window select
	cmc_layout_e layout_r; // register layout
	logic [4:0] code_r; // registered source code
	cmc_winbuf_e winbuf_r; // decoded window
	logic ack_r; // bus answer
	logic [31:0] dat_r; // read data
	logic acc; // request in flight
	logic wr_go; // write commits this edge
	logic wr_ctrl; // control write commits
	logic wr_lay; // layout write commits
	logic abort_set; // software sets abort
	logic [7:0] ctrl_view; // control read value
	logic [7:0] stat_view; // status read value

	assign acc = wb_cyc_i && wb_stb_i;
	// write lands at the edge the master sees ack
	assign wr_go = acc && wb_we_i && ack_r && wb_sel_i[0];
	assign wr_ctrl = wr_go && (wb_adr_i == CMC_OFS_CTRL);
	assign wr_lay = wr_go && (wb_adr_i == CMC_OFS_LAYOUT);
	assign abort_set = wr_ctrl && wb_dat_i[CMC_ABORT_BIT];

	// ************************************************
	// wishbone answer
	// ************************************************
	// one wait state, ack drops the cycle after it rose
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= acc && !ack_r;
		end
	end

	// read views, rebuilt per layout
	always_comb begin
		ctrl_view = {req_r, abort_r, 4'h0};
		// mode in effect on top bits
		stat_view = {mode_r, 5'h00};
		case (layout_r)
			LAY_LEGACY: begin
				ctrl_view[3:1] = win_r;
				// code bits 3-1 line up with window
				stat_view[3:1] = code_r[3:1];
			end
			LAY_FIFO: begin
				ctrl_view[3:0] = fifo_read_pointer_i;
				stat_view[4:0] = code_r;
			end
			default: begin
				stat_view[4:0] = code_r;
			end
		endcase
	end

	// read data captured with the answer; unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= 32'h0;
		end else if (acc && !ack_r && !wb_we_i) begin
			if (wb_adr_i == CMC_OFS_CTRL) begin
				dat_r <= {24'h0, ctrl_view};
			end else if (wb_adr_i == CMC_OFS_STAT) begin
				dat_r <= {24'h0, stat_view};
			end else if (wb_adr_i == CMC_OFS_LAYOUT) begin
				dat_r <= {30'h0, layout_r};
			end else if (wb_adr_i == CMC_OFS_TXPEND) begin
				dat_r <= {29'h0, tx_pending_i};
			end else begin
				dat_r <= 32'h0;
			end
		end
	end

	// ************************************************
	// control register
	// ************************************************
	// request and window; window only written in legacy layout
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_r <= CMC_REQ_RST;
			win_r <= CMC_WIN_RST;
		end else if (wr_ctrl) begin
			req_r <= wb_dat_i[CMC_REQ_LSB +: 3];
			if (layout_r == LAY_LEGACY) begin
				win_r <= wb_dat_i[CMC_WIN_LSB +: 3];
			end
		end
	end

	// layout changes only while configuration is in effect
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			layout_r <= LAY_LEGACY;
		end else if (wr_lay && mode_r == OP_CONFIG && wb_dat_i[1:0] != 2'h3) begin
			layout_r <= cmc_layout_e'(wb_dat_i[1:0]);
		end
	end

	// ************************************************
	// mode in effect
	// ************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_r <= OP_CONFIG;
		end else if (req_r[2]) begin
			// configuration waits for an idle bus
			if (bus_idle_i) begin
				mode_r <= OP_CONFIG;
			end
		end else begin
			// decode request, take it at once
			mode_r <= cmc_op_e'({1'b0, req_r[1:0]});
		end
	end

	// ************************************************
	// abort
	// ************************************************
	// a set in the clearing cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			abort_r <= 1'b0;
		end else if (abort_set) begin
			abort_r <= 1'b1;
		end else if (abort_r && tx_pending_i == 3'h0) begin
			abort_r <= 1'b0;
		end
	end

	// ************************************************
	// source code and window outputs
	// ************************************************
	// registered so a handler snapshot is stable for a cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_r <= CMC_IC_NONE;
			winbuf_r <= WB_RX0;
		end else begin
			code_r <= irq_code(irq_i, layout_r);
			winbuf_r <= win_decode(win_r);
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign mode_in_effect_o = mode_r;
	assign abort_all_tx_o = abort_r;
	assign buffer_window_o = winbuf_r;
	assign irq_source_code_o = code_r;

	// ************************************************
	// assertions
	// ************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_cfg_entry_idle: assert property ((mode_r != OP_CONFIG) ##1 (mode_r == OP_CONFIG)
		|-> $past(bus_idle_i)) else $error("config entered on busy bus");
	a_cfg_busy_hold: assert property ((req_r[2] && !bus_idle_i) |=> mode_r == $past(mode_r))
		else $error("mode changed on busy bus");
	a_other_mode_now: assert property (!req_r[2] |=> mode_r == {1'b0, $past(req_r[1:0])})
		else $error("mode not granted at once");
	a_abort_self_clr: assert property ((abort_r && tx_pending_i == 3'h0 && !abort_set)
		|=> !abort_r) else $error("abort not cleared");
	a_abort_holds: assert property ((abort_r && tx_pending_i != 3'h0) |=> abort_r)
		else $error("abort dropped early");
	a_code_none: assert property ((irq_i == '0) |=> code_r == CMC_IC_NONE)
		else $error("code not zero when idle");
	a_code_err: assert property (irq_i.bus_err |=> code_r == CMC_IC_ERR)
		else $error("bus error code wrong");
	// fifo layout: all receivers never report own code
	a_fifo_rx_remap: assert property ((layout_r == LAY_FIFO && !wr_lay && irq_i.prog_rx == 6'h3f)
		|=> code_r < CMC_IC_PROG0) else $error("receiver reported own code");
	a_legacy_fit: assert property ((layout_r == LAY_LEGACY && !wr_lay)
		|=> (code_r[4] == 1'b0 && code_r[0] == 1'b0)) else $error("legacy code misplaced");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");

	c_cfg_entry: cover property ((mode_r == OP_NORMAL) ##[1:20] (mode_r == OP_CONFIG));
	c_abort_done: cover property (abort_r ##1 !abort_r);
	c_fifo_remap: cover property (layout_r == LAY_FIFO && code_r == CMC_IC_E_RX0);
endmodule : cmc_mode_ctrl

// ---- verilog/cmc_pkg.sv ----
/*
 * constants, types and register map of the can mode control block.
 * assumes a wishbone slave wrapper and a protocol engine on the same clock.
 */
// Operation
// - mode request field decode, top bit configuration
// - status shows mode actually in effect
// - abort bit aborts all pending transmissions
// - abort self-clears; software cannot clear it
// - legacy window select maps one buffer
// - fifo layout: read-only read pointer, low bits
// - prioritized source code, zero when none
// - error and transmit codes same every layout
// - legacy codes for receive and wake-up
// - enhanced codes for receive, programmable; wake keeps legacy code
// - fifo layout: receiving programmable reports receive code
// - code placed to copy into window select
// - configuration request waits for bus idle
// - other mode requests granted at once
// - three layouts: legacy, enhanced, fifo
package cmc_pkg;
	// ************************************************
	// register map, byte addresses
	// ************************************************
	localparam logic [3:0] CMC_OFS_CTRL = 4'h0; // can_mode_control
	localparam logic [3:0] CMC_OFS_STAT = 4'h4; // can_mode_status
	localparam logic [3:0] CMC_OFS_LAYOUT = 4'h8; // layout select
	localparam logic [3:0] CMC_OFS_TXPEND = 4'hc; // pending transmit view
	// field positions
	localparam int CMC_REQ_LSB = 5;
	localparam int CMC_ABORT_BIT = 4;
	localparam int CMC_WIN_LSB = 1;
	// reset values
	localparam logic [2:0] CMC_REQ_RST = 3'h4;
	localparam logic [2:0] CMC_WIN_RST = 3'h0;
	// codes
	localparam logic [4:0] CMC_IC_NONE = 5'h00;
	localparam logic [4:0] CMC_IC_ERR = 5'h02;
	localparam logic [4:0] CMC_IC_TX2 = 5'h04;
	localparam logic [4:0] CMC_IC_TX1 = 5'h06;
	localparam logic [4:0] CMC_IC_TX0 = 5'h08;
	localparam logic [4:0] CMC_IC_L_RX1 = 5'h0a;
	localparam logic [4:0] CMC_IC_L_RX0 = 5'h0c;
	localparam logic [4:0] CMC_IC_WAKE = 5'h0e;
	localparam logic [4:0] CMC_IC_E_RX0 = 5'h10;
	localparam logic [4:0] CMC_IC_E_RX1 = 5'h11;
	localparam logic [4:0] CMC_IC_PROG0 = 5'h12;

	typedef enum logic [2:0] {
		OP_NORMAL = 3'h0,
		OP_SLEEP = 3'h1,
		OP_LOOPBACK = 3'h2,
		OP_LISTEN = 3'h3,
		OP_CONFIG = 3'h4
	} cmc_op_e;

	typedef enum logic [1:0] {
		LAY_LEGACY = 2'h0,
		LAY_ENH = 2'h1,
		LAY_FIFO = 2'h2
	} cmc_layout_e;

	typedef enum logic [2:0] {
		WB_RX0 = 3'h0,
		WB_RX1 = 3'h1,
		WB_TX0 = 3'h2,
		WB_TX1 = 3'h3,
		WB_TX2 = 3'h4
	} cmc_winbuf_e;

	// interrupt flag levels from the flag register
	typedef struct packed {
		logic bus_err;
		logic wake;
		logic [2:0] tx;
		logic [1:0] rx;
		logic [5:0] prog;
		logic [5:0] prog_rx;
	} cmc_irq_s;
endpackage : cmc_pkg
